// ==== design/accum_sign_apply.sv ====
// Sign handling of active and reactive powers before accumulation
module accum_sign_apply
    import energy_sel_pkg::*;
#(
    parameter int PW = PROD_W
) (
    input wire logic signed [PW-1:0] act_in,
    input wire logic signed [PW-1:0] react_in,
    input wire logic [1:0] act_mode,
    input wire logic [1:0] react_mode,
    output logic signed [PW-1:0] act_out,
    output logic signed [PW-1:0] react_out
);
    // Reserved codes fall back to signed handling
    always_comb begin
        act_out = act_in;
        if (act_mode == ACT_ABS && act_in < 0) begin
            act_out = -act_in;
        end
        react_out = react_in;
        // Reactive follows the sign of the raw, matching active power
        if (react_mode == REACT_BY_ACT && act_in < 0) begin
            react_out = -react_in;
        end
    end
endmodule

// ==== design/energy_accum_input_select.sv ====
// Energy accumulator input selector with APB configuration and reverse flags
//
// Local design decisions: the register offsets and register access over APB.
module energy_accum_input_select
    import energy_sel_pkg::*;
#(
    parameter int SW = SAMPLE_W,
    parameter int PW = PROD_W
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sample_valid,
    input wire logic signed [3*SW-1:0] volt,
    input wire logic signed [3*SW-1:0] curr,
    input wire logic signed [3*SW-1:0] curr_q,
    input wire logic [3*SW-1:0] volt_rms,
    input wire logic [3*SW-1:0] curr_rms,
    input wire logic signed [3*PW-1:0] fund_act,
    input wire logic signed [3*PW-1:0] fund_react,
    output logic [3*PW-1:0] act_pwr,
    output logic [3*PW-1:0] react_pwr,
    output logic [3*PW-1:0] app_pwr,
    output logic [3*PW-1:0] fund_act_pwr,
    output logic [3*PW-1:0] fund_react_pwr,
    output logic energy_valid,
    output logic [2:0] reverse_active_flag,
    output logic [2:0] reverse_reactive_flag
);
    // Configuration register and its fields
    logic [7:0] accumulation_mode_config_ff;
    logic [7:0] nxt_accumulation_mode_config;
    logic [1:0] active_accum_mode;
    logic [1:0] reactive_accum_mode;
    logic [1:0] wiring_config_select;
    logic reverse_active_source_sel;
    logic reverse_reactive_source_sel;
    // Sticky status flags
    logic [12:0] primary_event_status_ff;
    logic [12:0] nxt_primary_event_status;
    // Bus decode
    logic wr_access;
    logic rd_setup;
    logic hit_cfg;
    logic hit_status;
    logic [31:0] prdata_ff;
    logic [31:0] nxt_prdata;
    // Per-phase datapath signals
    logic signed [SW+1:0] volt_eff [3];
    logic zero_phase [3];
    logic signed [PW-1:0] raw_act [3];
    logic signed [PW-1:0] raw_react [3];
    logic signed [PW-1:0] raw_app [3];
    logic signed [PW-1:0] sel_fact [3];
    logic signed [PW-1:0] sel_freact [3];
    logic signed [PW-1:0] adj_act [3];
    logic signed [PW-1:0] adj_react [3];
    logic signed [PW-1:0] adj_fact [3];
    logic signed [PW-1:0] adj_freact [3];
    // Registered outputs
    logic [3*PW-1:0] act_ff, react_ff, app_ff, fact_ff, freact_ff;
    logic [3*PW-1:0] nxt_act, nxt_react, nxt_app, nxt_fact, nxt_freact;
    logic valid_ff;
    logic nxt_valid;

    // Widen a phase voltage sample to the product operand width
    function automatic logic signed [SW+1:0] widen(input logic signed [SW-1:0] v);
        widen = {{2{v[SW-1]}}, v};
    endfunction

    // Field extraction
    assign active_accum_mode = accumulation_mode_config_ff[ACT_LSB +: 2];
    assign reactive_accum_mode = accumulation_mode_config_ff[REACT_LSB +: 2];
    assign wiring_config_select = accumulation_mode_config_ff[WIRE_LSB +: 2];
    assign reverse_active_source_sel = accumulation_mode_config_ff[REV_ACT_BIT];
    assign reverse_reactive_source_sel = accumulation_mode_config_ff[REV_REACT_BIT];

    // APB decode; zero wait states, so pready stays high
    assign wr_access = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;
    assign hit_cfg = (paddr == CFG_ADDR);
    assign hit_status = (paddr == STATUS_ADDR);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !(hit_cfg || hit_status);
    assign prdata = prdata_ff;

    // Phase B voltage and presence follow the wiring arrangement
    always_comb begin
        volt_eff[0] = widen(volt[0 +: SW]);
        volt_eff[2] = widen(volt[2*SW +: SW]);
        zero_phase[0] = 1'b0;
        zero_phase[1] = 1'b0;
        zero_phase[2] = 1'b0;
        unique case (wiring_config_select)
            WIRE_4W_3V: begin
                volt_eff[1] = widen(volt[SW +: SW]);
            end
            WIRE_3W_DELTA: begin
                volt_eff[1] = '0;
                zero_phase[1] = 1'b1;
            end
            WIRE_4W_2V: begin
                volt_eff[1] = -volt_eff[0] - volt_eff[2];
            end
            WIRE_4W_DELTA: begin
                volt_eff[1] = -volt_eff[0];
            end
        endcase
    end

    // One product unit and two sign units per phase, one each for total and fundamental
    for (genvar p = 0; p < 3; p++) begin : g_phase
        // Quadrature current drives the reactive product
        phase_power_product #(.SW(SW)) u_prod (
            .volt(volt_eff[p]),
            .curr(curr[p*SW +: SW]),
            .curr_q(curr_q[p*SW +: SW]),
            .volt_rms(volt_rms[p*SW +: SW]),
            .curr_rms(curr_rms[p*SW +: SW]),
            .zero_phase(zero_phase[p]),
            .active(raw_act[p]),
            .reactive(raw_react[p]),
            .apparent(raw_app[p])
        );
        // Fundamental powers of an absent phase are zero too
        assign sel_fact[p] = zero_phase[p] ? '0 : fund_act[p*PW +: PW];
        assign sel_freact[p] = zero_phase[p] ? '0 : fund_react[p*PW +: PW];
        accum_sign_apply #(.PW(PW)) u_tot (
            .act_in(raw_act[p]),
            .react_in(raw_react[p]),
            .act_mode(active_accum_mode),
            .react_mode(reactive_accum_mode),
            .act_out(adj_act[p]),
            .react_out(adj_react[p])
        );
        accum_sign_apply #(.PW(PW)) u_fund (
            .act_in(sel_fact[p]),
            .react_in(sel_freact[p]),
            .act_mode(active_accum_mode),
            .react_mode(reactive_accum_mode),
            .act_out(adj_fact[p]),
            .react_out(adj_freact[p])
        );
    end

    // Next state of configuration, status, read data and power outputs
    always_comb begin
        nxt_accumulation_mode_config = accumulation_mode_config_ff;
        nxt_primary_event_status = primary_event_status_ff;
        nxt_prdata = prdata_ff;
        nxt_act = act_ff;
        nxt_react = react_ff;
        nxt_app = app_ff;
        nxt_fact = fact_ff;
        nxt_freact = freact_ff;
        nxt_valid = 1'b0;
        // Config write lands at the access edge; held energy is untouched
        if (wr_access && hit_cfg && pstrb[0]) begin
            nxt_accumulation_mode_config = pwdata[7:0];
        end
        // Write one to clear; a same-cycle set below wins
        if (wr_access && hit_status) begin
            nxt_primary_event_status = primary_event_status_ff &
                ~(pwdata[12:0] & STATUS_MASK & {13{pstrb[0] | pstrb[1]}});
        end
        // Read data captured in the setup cycle
        if (rd_setup) begin
            if (hit_cfg) begin
                nxt_prdata = {24'h000000, accumulation_mode_config_ff};
            end else if (hit_status) begin
                nxt_prdata = {19'h00000, primary_event_status_ff};
            end else begin
                nxt_prdata = 32'h0000_0000;
            end
        end
        // Each update uses the configuration in force at that edge
        if (sample_valid) begin
            nxt_valid = 1'b1;
            for (int p = 0; p < 3; p++) begin
                nxt_act[p*PW +: PW] = adj_act[p];
                nxt_react[p*PW +: PW] = adj_react[p];
                nxt_app[p*PW +: PW] = raw_app[p];
                nxt_fact[p*PW +: PW] = adj_fact[p];
                nxt_freact[p*PW +: PW] = adj_freact[p];
                // Reverse active source: total or fundamental
                if ((reverse_active_source_sel ? sel_fact[p] : raw_act[p]) < 0) begin
                    nxt_primary_event_status[REV_ACT_A_BIT + p] = 1'b1;
                end
                // Reverse reactive source: total or fundamental
                if ((reverse_reactive_source_sel ? sel_freact[p] : raw_react[p]) < 0) begin
                    nxt_primary_event_status[REV_REACT_A_BIT + p] = 1'b1;
                end
            end
        end
    end

    // Register stage
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            accumulation_mode_config_ff <= CFG_RESET;
            primary_event_status_ff <= STATUS_RESET;
            prdata_ff <= '0;
            act_ff <= '0;
            react_ff <= '0;
            app_ff <= '0;
            fact_ff <= '0;
            freact_ff <= '0;
            valid_ff <= 1'b0;
        end else begin
            accumulation_mode_config_ff <= nxt_accumulation_mode_config;
            primary_event_status_ff <= nxt_primary_event_status;
            prdata_ff <= nxt_prdata;
            act_ff <= nxt_act;
            react_ff <= nxt_react;
            app_ff <= nxt_app;
            fact_ff <= nxt_fact;
            freact_ff <= nxt_freact;
            valid_ff <= nxt_valid;
        end
    end

    assign act_pwr = act_ff;
    assign react_pwr = react_ff;
    assign app_pwr = app_ff;
    assign fund_act_pwr = fact_ff;
    assign fund_react_pwr = freact_ff;
    assign energy_valid = valid_ff;
    assign reverse_active_flag = primary_event_status_ff[REV_ACT_A_BIT +: 3];
    assign reverse_reactive_flag = primary_event_status_ff[REV_REACT_A_BIT +: 3];

    // Config write is visible on the following cycle
    property p_cfg_write;
        @(posedge ref_clk) disable iff (!arst_n)
        (wr_access && hit_cfg && pstrb[0]) |=> accumulation_mode_config_ff == $past(pwdata[7:0]);
    endproperty
    a_cfg_write: assert property (p_cfg_write) else $error("config write lost");

    // Delta three-wire zeroes phase B active, reactive and apparent outputs
    property p_delta_zero;
        @(posedge ref_clk) disable iff (!arst_n)
        (sample_valid && wiring_config_select == WIRE_3W_DELTA) |=>
            act_ff[PW +: PW] == '0 && react_ff[PW +: PW] == '0 && app_ff[PW +: PW] == '0;
    endproperty
    a_delta_zero: assert property (p_delta_zero) else $error("phase B not zero");

    // Two-sensor wiring derives phase B from A and C
    property p_two_sensor;
        @(posedge ref_clk) disable iff (!arst_n)
        (sample_valid && wiring_config_select == WIRE_4W_2V) |->
            volt_eff[1] == -widen(volt[0 +: SW]) - widen(volt[2*SW +: SW]);
    endproperty
    a_two_sensor: assert property (p_two_sensor) else $error("derived B wrong");

    // Four-wire delta takes phase B as negated A
    property p_delta_4w;
        @(posedge ref_clk) disable iff (!arst_n)
        (wiring_config_select == WIRE_4W_DELTA) |-> volt_eff[1] == -widen(volt[0 +: SW]);
    endproperty
    a_delta_4w: assert property (p_delta_4w) else $error("B not -A");

    // Sign-by-active flips phase A reactive when active is negative
    property p_react_flip;
        @(posedge ref_clk) disable iff (!arst_n)
        (sample_valid && reactive_accum_mode == REACT_BY_ACT && raw_act[0] < 0) |=>
            $signed(react_ff[0 +: PW]) == -$past(raw_react[0]);
    endproperty
    a_react_flip: assert property (p_react_flip) else $error("reactive not flipped");

    // Other reactive codes keep the sign
    property p_react_keep;
        @(posedge ref_clk) disable iff (!arst_n)
        (sample_valid && reactive_accum_mode != REACT_BY_ACT) |=>
            $signed(react_ff[0 +: PW]) == $past(raw_react[0]);
    endproperty
    a_react_keep: assert property (p_react_keep) else $error("reactive sign changed");

    // Absolute mode never yields a negative active output
    property p_act_abs;
        @(posedge ref_clk) disable iff (!arst_n)
        (sample_valid && active_accum_mode == ACT_ABS) |=> $signed(act_ff[0 +: PW]) >= 0;
    endproperty
    a_act_abs: assert property (p_act_abs) else $error("abs mode negative");

    // Negative selected active power raises the phase A flag; a same-cycle clear loses
    property p_rev_act;
        @(posedge ref_clk) disable iff (!arst_n)
        (sample_valid && (reverse_active_source_sel ? sel_fact[0] : raw_act[0]) < 0)
            |=> primary_event_status_ff[REV_ACT_A_BIT];
    endproperty
    a_rev_act: assert property (p_rev_act) else $error("reverse active flag missed");

    // Reverse reactive flag uses the selected source
    property p_rev_react;
        @(posedge ref_clk) disable iff (!arst_n)
        (sample_valid && (reverse_reactive_source_sel ? sel_freact[2] : raw_react[2]) < 0)
            |=> primary_event_status_ff[REV_REACT_A_BIT + 2];
    endproperty
    a_rev_react: assert property (p_rev_react) else $error("reverse reactive flag missed");

    // Without an update strobe the power outputs keep what they hold
    property p_outputs_hold;
        @(posedge ref_clk) disable iff (!arst_n)
        !sample_valid |=> $stable(act_ff) && $stable(react_ff) && $stable(app_ff);
    endproperty
    a_outputs_hold: assert property (p_outputs_hold) else $error("power moved without update");

    // The update pulse follows the strobe by one cycle
    property p_valid_follow;
        @(posedge ref_clk) disable iff (!arst_n)
        sample_valid |=> energy_valid;
    endproperty
    a_valid_follow: assert property (p_valid_follow) else $error("update pulse missing");

    // Phase A apparent power is the full rms product
    property p_app_a;
        @(posedge ref_clk) disable iff (!arst_n)
        sample_valid |=>
            app_ff[0 +: PW] == $past(volt_rms[0 +: SW]) * $past(curr_rms[0 +: SW]);
    endproperty
    a_app_a: assert property (p_app_a) else $error("apparent product wrong");

    // Delta three-wire zeroes the fundamental phase B outputs as well
    property p_delta_fund_zero;
        @(posedge ref_clk) disable iff (!arst_n)
        (sample_valid && wiring_config_select == WIRE_3W_DELTA) |=>
            fact_ff[PW +: PW] == '0 && freact_ff[PW +: PW] == '0;
    endproperty
    a_delta_fund_zero: assert property (p_delta_fund_zero) else $error("fund B not zero");

    // Writing one clears the phase A reverse active flag when no set competes
    property p_status_clear;
        @(posedge ref_clk) disable iff (!arst_n)
        (wr_access && hit_status && pstrb[0] && pwdata[REV_ACT_A_BIT] && !sample_valid)
            |=> !primary_event_status_ff[REV_ACT_A_BIT];
    endproperty
    a_status_clear: assert property (p_status_clear) else $error("flag not cleared");
endmodule

// ==== design/energy_sel_pkg.sv ====
// Shared constants, field layout and mode encodings for the accumulator input selector
package energy_sel_pkg;
    // Sample and rms width out of the DSP
    localparam int SAMPLE_W = 24;
    // Product width: voltage widened by two bits for the derived phase B
    localparam int PROD_W = 2 * SAMPLE_W + 2;
    // Register indices; byte address is four times the index
    localparam logic [15:0] CFG_IDX = 16'hE701;
    localparam logic [15:0] STATUS_IDX = 16'hE710;
    localparam int ADDR_W = 18;
    localparam logic [ADDR_W-1:0] CFG_ADDR = {CFG_IDX, 2'b00};
    localparam logic [ADDR_W-1:0] STATUS_ADDR = {STATUS_IDX, 2'b00};
    // Configuration field positions
    localparam int ACT_LSB = 0;
    localparam int REACT_LSB = 2;
    localparam int WIRE_LSB = 4;
    localparam int REV_ACT_BIT = 6;
    localparam int REV_REACT_BIT = 7;
    localparam logic [7:0] CFG_RESET = 8'h00;
    // Status bit positions of the reverse power flags, phase A first
    localparam int REV_ACT_A_BIT = 6;
    localparam int REV_REACT_A_BIT = 10;
    localparam logic [12:0] STATUS_RESET = 13'h0000;
    localparam logic [12:0] STATUS_MASK = 13'h1DC0;
    // Active accumulation modes
    typedef enum logic [1:0] {
        ACT_SIGNED = 2'b00,
        ACT_RSVD1 = 2'b01,
        ACT_RSVD2 = 2'b10,
        ACT_ABS = 2'b11
    } act_mode_t;
    // Reactive accumulation modes
    typedef enum logic [1:0] {
        REACT_SIGNED = 2'b00,
        REACT_RSVD1 = 2'b01,
        REACT_BY_ACT = 2'b10,
        REACT_RSVD3 = 2'b11
    } react_mode_t;
    // Wiring arrangements
    typedef enum logic [1:0] {
        WIRE_4W_3V = 2'b00,
        WIRE_3W_DELTA = 2'b01,
        WIRE_4W_2V = 2'b10,
        WIRE_4W_DELTA = 2'b11
    } wiring_t;
endpackage

// ==== design/phase_power_product.sv ====
// Per-phase active, reactive and apparent power products
module phase_power_product
    import energy_sel_pkg::*;
#(
    parameter int SW = SAMPLE_W
) (
    input wire logic signed [SW+1:0] volt,
    input wire logic signed [SW-1:0] curr,
    input wire logic signed [SW-1:0] curr_q,
    input wire logic [SW-1:0] volt_rms,
    input wire logic [SW-1:0] curr_rms,
    input wire logic zero_phase,
    output logic signed [2*SW+1:0] active,
    output logic signed [2*SW+1:0] reactive,
    output logic signed [2*SW+1:0] apparent
);
    // Full-width rms product; inside a concatenation it would shrink to the operand width
    logic [2*SW-1:0] rms_prod;
    assign rms_prod = volt_rms * curr_rms;

    // Products, forced to zero when the phase is absent from the wiring
    always_comb begin
        if (zero_phase) begin
            active = '0;
            reactive = '0;
            apparent = '0;
        end else begin
            active = volt * curr;
            // Current already lags by a quarter cycle
            reactive = volt * curr_q;
            apparent = $signed({2'b00, rms_prod});
        end
    end
endmodule

// ==== sim/tb.sv ====
// Self-checking bench for the energy accumulator input selector
module tb
    import energy_sel_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;

    // Clock, reset and APB side
    logic ref_clk, arst_n, psel, penable, pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb;
    logic pready, pslverr;
    // Sample side, phase A in the low slice
    logic sample_valid, energy_valid;
    logic signed [3*SAMPLE_W-1:0] volt, curr, curr_q;
    logic [3*SAMPLE_W-1:0] volt_rms, curr_rms;
    logic signed [3*PROD_W-1:0] fund_act, fund_react;
    logic [3*PROD_W-1:0] act_pwr, react_pwr, app_pwr, fund_act_pwr, fund_react_pwr;
    logic [2:0] reverse_active_flag, reverse_reactive_flag;
    // Per-phase stimulus and expectations
    logic signed [23:0] v[3], i[3], q[3];
    logic [23:0] vr[3], ir[3];
    logic signed [49:0] fa[3], fr[3];
    logic [149:0] e_act, e_react, e_app, e_fa, e_fr, held;
    logic [2:0] e_ra, e_rr;
    logic [31:0] seed, rd, r32;
    logic [63:0] w;
    logic er;
    int error_cnt, samples_checked;

    energy_accum_input_select dut (
        .ref_clk(ref_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sample_valid(sample_valid), .volt(volt), .curr(curr), .curr_q(curr_q),
        .volt_rms(volt_rms), .curr_rms(curr_rms), .fund_act(fund_act),
        .fund_react(fund_react), .act_pwr(act_pwr), .react_pwr(react_pwr),
        .app_pwr(app_pwr), .fund_act_pwr(fund_act_pwr), .fund_react_pwr(fund_react_pwr),
        .energy_valid(energy_valid), .reverse_active_flag(reverse_active_flag),
        .reverse_reactive_flag(reverse_reactive_flag)
    );

    // Free-running 20 MHz clock
    always #25 ref_clk = ~ref_clk;

    // Repeatable xorshift source
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Single compare task; wide enough for three packed phases
    task automatic chk(input string nm, input logic [149:0] e, input logic [149:0] g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask

    // Verdict and end of run
    task automatic finish_test();
        $display("errors %0d checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // One APB transfer; request held until pready is seen high at an edge
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) error_cnt++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Present one sample set for a single update strobe
    task automatic send_sample();
        int n;
        n = 0;
        @(posedge ref_clk);
        sample_valid <= 1'b1;
        volt <= {v[2], v[1], v[0]};
        curr <= {i[2], i[1], i[0]};
        curr_q <= {q[2], q[1], q[0]};
        volt_rms <= {vr[2], vr[1], vr[0]};
        curr_rms <= {ir[2], ir[1], ir[0]};
        fund_act <= {fa[2], fa[1], fa[0]};
        fund_react <= {fr[2], fr[1], fr[0]};
        @(posedge ref_clk);
        sample_valid <= 1'b0;
        #1;
        // Bounded wait in case the update lands late
        while (energy_valid !== 1'b1 && n < 8) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
    endtask

    // Reference model of the selection and sign handling
    task automatic model(input logic [7:0] c);
        longint a, r, s, fa0, fr0, vv;
        logic zb;
        for (int p = 0; p < 3; p++) begin
            // Three-wire delta wiring removes phase B entirely
            zb = (c[5:4] == 2'b01) && (p == 1);
            vv = v[p];
            if (p == 1 && c[5:4] == 2'b10) vv = -(longint'(v[0]) + longint'(v[2]));
            if (p == 1 && c[5:4] == 2'b11) vv = -longint'(v[0]);
            a = zb ? 0 : vv * i[p];
            r = zb ? 0 : vv * q[p];
            s = zb ? 0 : longint'(vr[p]) * longint'(ir[p]);
            fa0 = zb ? 0 : fa[p];
            fr0 = zb ? 0 : fr[p];
            // Flags look at raw powers, before any sign mode
            e_ra[p] = c[6] ? (fa0 < 0) : (a < 0);
            e_rr[p] = c[7] ? (fr0 < 0) : (r < 0);
            if (c[3:2] == 2'b10) begin
                if (a < 0) r = -r;
                if (fa0 < 0) fr0 = -fr0;
            end
            if (c[1:0] == 2'b11) begin
                if (a < 0) a = -a;
                if (fa0 < 0) fa0 = -fa0;
            end
            e_act[p*50 +: 50] = a[49:0];
            e_react[p*50 +: 50] = r[49:0];
            e_app[p*50 +: 50] = s[49:0];
            e_fa[p*50 +: 50] = fa0[49:0];
            e_fr[p*50 +: 50] = fr0[49:0];
        end
    endtask

    // Watchdog sized well above the expected run length
    initial begin
        #(50 * 40000);
        error_cnt++;
        finish_test();
    end

    // Main sequence
    initial begin
        seed = 32'h2;
        error_cnt = 0;
        samples_checked = 0;
        ref_clk = 1'b0;
        arst_n = 1'b0;
        {psel, penable, pwrite, sample_valid} = 4'h0;
        paddr = '0;
        pwdata = 32'h0;
        pstrb = 4'hF;
        {volt, curr, curr_q, volt_rms, curr_rms, fund_act, fund_react} = '0;
        repeat (12) @(posedge ref_clk);
        arst_n <= 1'b1;
        apb(1'b0, CFG_ADDR, 32'h0);
        chk("cfg_rst", CFG_RESET, rd);
        apb(1'b0, STATUS_ADDR, 32'h0);
        chk("stat_rst", STATUS_RESET, rd);
        // Unmapped place: refused, reads zero, config untouched
        apb(1'b1, 18'h00100, 32'hFF);
        chk("err_w", 1'b1, er);
        apb(1'b0, 18'h00100, 32'h0);
        chk("err_r", 1'b1, er);
        chk("rd_unmap", 32'h0, rd);
        // Config write without its byte strobe is ignored
        pstrb <= 4'hE;
        apb(1'b1, CFG_ADDR, 32'hFF);
        pstrb <= 4'hF;
        apb(1'b0, CFG_ADDR, 32'h0);
        chk("cfg_kept", CFG_RESET, rd);
        // Every configuration value, random samples, extremes first
        for (int k = 0; k < 256; k++) begin
            held = act_pwr;
            r32 = rnd();
            apb(1'b1, CFG_ADDR, {r32[31:8], k[7:0]});
            chk("hold", held, act_pwr);
            apb(1'b0, CFG_ADDR, 32'h0);
            chk("cfg_rb", {24'h0, k[7:0]}, rd);
            chk("ok_err", 1'b0, er);
            apb(1'b1, STATUS_ADDR, 32'h1DC0);
            for (int p = 0; p < 3; p++) begin
                if (k < 8) begin
                    v[p] = 24'h800000;
                    i[p] = k[0] ? 24'h7FFFFF : 24'h800000;
                    q[p] = 24'h7FFFFF;
                    vr[p] = 24'hFFFFFF;
                    ir[p] = 24'hFFFFFF;
                    fa[p] = k[1] ? 50'h3FFFFFFFFFFFF : 50'h1;
                    fr[p] = 50'h3FFFFFFFFFFFF;
                end else begin
                    r32 = rnd();
                    v[p] = r32[23:0];
                    r32 = rnd();
                    i[p] = r32[23:0];
                    r32 = rnd();
                    q[p] = r32[23:0];
                    r32 = rnd();
                    vr[p] = r32[23:0];
                    r32 = rnd();
                    ir[p] = r32[23:0];
                    w = {rnd(), rnd()};
                    fa[p] = w[49:0];
                    w = {rnd(), rnd()};
                    fr[p] = w[49:0];
                end
            end
            send_sample();
            model(k[7:0]);
            chk("valid", 1'b1, energy_valid);
            chk("act", e_act, act_pwr);
            chk("react", e_react, react_pwr);
            chk("app", e_app, app_pwr);
            chk("f_act", e_fa, fund_act_pwr);
            chk("f_react", e_fr, fund_react_pwr);
            chk("rev_act", e_ra, reverse_active_flag);
            chk("rev_react", e_rr, reverse_reactive_flag);
            apb(1'b0, STATUS_ADDR, 32'h0);
            chk("status", {19'h0, e_rr, 1'b0, e_ra, 6'h0}, rd);
        end
        // Mid-run reset returns outputs and configuration to their reset state
        @(posedge ref_clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge ref_clk);
        chk("rst_act", '0, act_pwr);
        chk("rst_valid", 1'b0, energy_valid);
        chk("rst_flag", 3'h0, reverse_reactive_flag);
        arst_n <= 1'b1;
        apb(1'b0, CFG_ADDR, 32'h0);
        chk("cfg_rst2", CFG_RESET, rd);
        finish_test();
    end
endmodule
